// ==== verilog/lie_regs.svh ====
// Offsets, field positions, reset values and timing counts of the link event block
// How it works
// - PHY status request sets bit 19
// - Missing link clock sets bit 18 before next access
// - PHY bus reset entry sets bit 17
// - Self-ID stream received sets bit 16
// - Bus reset set clears bit 16
// - Bit 15 sets with 16, survives reset
// - Bits 14 to 10 read zero, ignore writes
// - Unacked lock response sets bit 9
// - Host error on acked write sets bit 8
// - Bit 7 unlatched OR of receive event&mask
// - Bit 6 unlatched OR of transmit event&mask
// - Response packet stored sets bit 5
// - Request packet stored sets bit 4
// - Receive response descriptor completion sets bit 3
// - Receive request descriptor completion sets bit 2
// - Response transmit completion sets bit 1
// - Request transmit completion sets bit 0
// - Set and clear ports at adjacent offsets
// - Interrupt needs global enable and masked event
`ifndef LIE_REGS_SVH
`define LIE_REGS_SVH

// ==========================================================
// Register offsets (byte addresses)
`define LIE_EVENT_SET_OFS 8'h80
`define LIE_EVENT_CLR_OFS 8'h84
`define LIE_MASK_SET_OFS 8'h88
`define LIE_MASK_CLR_OFS 8'h8c

// ==========================================================
// Field positions
`define LIE_BIT_PHY_STATUS 19
`define LIE_BIT_REG_FAIL 18
`define LIE_BIT_BUS_RESET 17
`define LIE_BIT_IDENT_PRI 16
`define LIE_BIT_IDENT_SEC 15
`define LIE_BIT_LOCK_ERR 9
`define LIE_BIT_POSTED_ERR 8
`define LIE_BIT_ISO_RX 7
`define LIE_BIT_ISO_TX 6
`define LIE_BIT_RSP_PKT 5
`define LIE_BIT_REQ_PKT 4
`define LIE_BIT_ARX_RSP 3
`define LIE_BIT_ARX_REQ 2
`define LIE_BIT_ATX_RSP 1
`define LIE_BIT_ATX_REQ 0
`define LIE_BIT_GLOBAL_EN 31

// ==========================================================
// Masks and reset values
`define LIE_LATCHED_MASK 32'h000f_833f
`define LIE_MASK_RW_MASK 32'h800f_83ff
`define LIE_EVENT_RESET 32'h0000_0000
`define LIE_MASK_RESET 32'h0000_0000

// ==========================================================
// Bus responses
`define LIE_RESP_OKAY 2'b00
`define LIE_RESP_SLVERR 2'b10

// ==========================================================
// Link clock watchdog
`define LIE_AXI_CLK_MHZ 200
`define LIE_LINK_TIMEOUT_NS 320
`define LIE_LINK_TIMEOUT_CYC ((`LIE_LINK_TIMEOUT_NS * `LIE_AXI_CLK_MHZ) / 1000)

`endif

// ==== verilog/lie_pkg.sv ====
// Types shared by the link event block
`default_nettype none
package lie_pkg;
	// Same-domain event pulses from the controller's DMA and link logic
	typedef struct packed {
		logic ident_done;
		logic lock_resp_unacked;
		logic acked_write_host_err;
		logic rsp_packet_stored;
		logic req_packet_stored;
		logic arx_rsp_done;
		logic arx_req_done;
		logic atx_rsp_done;
		logic atx_req_done;
		logic phy_reg_access_start;
	} lie_event_in_type;
	// Levels arriving from the PHY side, outside the clock domain
	typedef struct packed {
		logic status_req;
		logic bus_reset_state;
		logic link_clk;
	} lie_phy_in_type;
endpackage
`default_nettype wire

// ==== verilog/lie_event_low.sv ====
// Interrupt event flags, mask and AXI4-Lite slave of the link controller
//
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "lie_regs.svh"

module lie_event_low
	import lie_pkg::*;
#(
	parameter int ADDR_W = 8,
	parameter int NUM_IR = 4,
	parameter int NUM_IT = 4,
	parameter int LINK_TIMEOUT = `LIE_LINK_TIMEOUT_CYC
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire lie_event_in_type event_in,
	input wire lie_phy_in_type phy_in,
	input wire logic [NUM_IR-1:0] iso_rx_ctx_event,
	input wire logic [NUM_IR-1:0] iso_rx_ctx_mask,
	input wire logic [NUM_IT-1:0] iso_tx_ctx_event,
	input wire logic [NUM_IT-1:0] iso_tx_ctx_mask,
	output logic host_irq
);

	// ==========================================================
	// Parameter checks
	initial begin
		if (ADDR_W < 8 || NUM_IR < 1 || NUM_IR > 32 || NUM_IT < 1 || NUM_IT > 32
			|| LINK_TIMEOUT < 1 || LINK_TIMEOUT > 65535) begin
			$error("lie_event_low: unsupported parameter value");
		end
	end

	// ==========================================================
	// PHY side synchronisers
	lie_phy_in_type phy_meta;
	lie_phy_in_type phy_sync;
	lie_phy_in_type phy_prev;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			phy_meta <= '0;
			phy_sync <= '0;
			phy_prev <= '0;
		end else begin
			phy_meta <= phy_in;
			phy_sync <= phy_meta;
			phy_prev <= phy_sync;
		end
	end

	logic phy_status_rise;
	logic bus_reset_rise;
	logic link_clk_edge;

	always_comb begin
		phy_status_rise = phy_sync.status_req & ~phy_prev.status_req;
		bus_reset_rise = phy_sync.bus_reset_state & ~phy_prev.bus_reset_state;
		link_clk_edge = phy_sync.link_clk & ~phy_prev.link_clk;
	end

	// ==========================================================
	// Link clock watchdog for PHY register accesses
	// An access that sees no link clock edge within the timeout has failed.
	// A new access while one is still unconfirmed also counts as failed, so
	// the flag is up before the next access proceeds.
	logic access_pending;
	logic [15:0] access_count;
	logic next_access_pending;
	logic [15:0] next_access_count;
	logic access_failed;

	always_comb begin
		next_access_pending = access_pending;
		next_access_count = access_count;
		access_failed = 1'b0;
		if (access_pending) begin
			next_access_count = access_count + 16'h0001;
			if (link_clk_edge) begin
				next_access_pending = 1'b0;
			end else if (access_count == 16'(LINK_TIMEOUT - 1)) begin
				access_failed = 1'b1;
				next_access_pending = 1'b0;
			end
		end
		if (event_in.phy_reg_access_start) begin
			if (access_pending && !link_clk_edge) begin
				access_failed = 1'b1;
			end
			next_access_pending = 1'b1;
			next_access_count = 16'h0000;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			access_pending <= 1'b0;
			access_count <= 16'h0000;
		end else begin
			access_pending <= next_access_pending;
			access_count <= next_access_count;
		end
	end

	// ==========================================================
	// AXI4-Lite write path
	// Address and data are taken independently and held until both are in.
	logic aw_held;
	logic w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic next_aw_held;
	logic next_w_held;
	logic [7:0] next_aw_addr;
	logic [31:0] next_w_data;
	logic [3:0] next_w_strb;
	logic next_bvalid;
	logic [1:0] next_bresp;
	logic wr_fire;
	logic [31:0] wr_bits;

	always_comb begin
		next_aw_held = aw_held;
		next_w_held = w_held;
		next_aw_addr = aw_addr;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bvalid = s_axi_bvalid;
		next_bresp = s_axi_bresp;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_held = 1'b1;
			next_aw_addr = {s_axi_awaddr[7:2], 2'b00};
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		wr_fire = aw_held && w_held && !s_axi_bvalid;
		wr_bits = '0;
		for (int i = 0; i < 4; i++) begin
			wr_bits[i*8 +: 8] = w_strb[i] ? w_data[i*8 +: 8] : 8'h00;
		end
		if (wr_fire) begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			unique case (aw_addr)
				`LIE_EVENT_SET_OFS, `LIE_EVENT_CLR_OFS,
				`LIE_MASK_SET_OFS, `LIE_MASK_CLR_OFS: next_bresp = `LIE_RESP_OKAY;
				default: next_bresp = `LIE_RESP_SLVERR;
			endcase
		end else if (s_axi_bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
	end

	// ==========================================================
	// Event flags and mask
	logic [31:0] flags;
	logic [31:0] mask;
	logic iso_rx_summary;
	logic iso_tx_summary;
	logic [31:0] next_flags;
	logic [31:0] next_mask;
	logic next_iso_rx_summary;
	logic next_iso_tx_summary;
	logic [31:0] hw_set;
	logic [31:0] sw_set;
	logic [31:0] sw_clr;
	logic [31:0] event_view;
	logic next_host_irq;

	always_comb begin
		next_iso_rx_summary = |(iso_rx_ctx_event & iso_rx_ctx_mask);
		next_iso_tx_summary = |(iso_tx_ctx_event & iso_tx_ctx_mask);
		hw_set = '0;
		hw_set[`LIE_BIT_PHY_STATUS] = phy_status_rise;
		hw_set[`LIE_BIT_REG_FAIL] = access_failed;
		hw_set[`LIE_BIT_BUS_RESET] = bus_reset_rise;
		hw_set[`LIE_BIT_IDENT_PRI] = event_in.ident_done;
		hw_set[`LIE_BIT_IDENT_SEC] = event_in.ident_done;
		hw_set[`LIE_BIT_LOCK_ERR] = event_in.lock_resp_unacked;
		hw_set[`LIE_BIT_POSTED_ERR] = event_in.acked_write_host_err;
		hw_set[`LIE_BIT_RSP_PKT] = event_in.rsp_packet_stored;
		hw_set[`LIE_BIT_REQ_PKT] = event_in.req_packet_stored;
		hw_set[`LIE_BIT_ARX_RSP] = event_in.arx_rsp_done;
		hw_set[`LIE_BIT_ARX_REQ] = event_in.arx_req_done;
		hw_set[`LIE_BIT_ATX_RSP] = event_in.atx_rsp_done;
		hw_set[`LIE_BIT_ATX_REQ] = event_in.atx_req_done;
		sw_set = '0;
		sw_clr = '0;
		next_mask = mask;
		if (wr_fire) begin
			unique case (aw_addr)
				`LIE_EVENT_SET_OFS: sw_set = wr_bits;
				`LIE_EVENT_CLR_OFS: sw_clr = wr_bits;
				`LIE_MASK_SET_OFS: next_mask = mask | (wr_bits & `LIE_MASK_RW_MASK);
				`LIE_MASK_CLR_OFS: next_mask = mask & ~(wr_bits & `LIE_MASK_RW_MASK);
				default: next_mask = mask;
			endcase
		end
		// Clear first, then sets, so a software clear never loses a hardware event
		next_flags = ((flags & ~sw_clr) | sw_set | hw_set) & `LIE_LATCHED_MASK;
		if (bus_reset_rise) begin
			next_flags[`LIE_BIT_IDENT_PRI] = 1'b0;
		end
		event_view = flags;
		event_view[`LIE_BIT_ISO_RX] = iso_rx_summary;
		event_view[`LIE_BIT_ISO_TX] = iso_tx_summary;
		// Bits 31:20 and 14:10 of the view are always zero, so only 19:0 can fire
		next_host_irq = mask[`LIE_BIT_GLOBAL_EN] && |(event_view & mask);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `LIE_RESP_OKAY;
			flags <= `LIE_EVENT_RESET;
			mask <= `LIE_MASK_RESET;
			iso_rx_summary <= 1'b0;
			iso_tx_summary <= 1'b0;
			host_irq <= 1'b0;
		end else begin
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			aw_addr <= next_aw_addr;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
			flags <= next_flags;
			mask <= next_mask;
			iso_rx_summary <= next_iso_rx_summary;
			iso_tx_summary <= next_iso_tx_summary;
			host_irq <= next_host_irq;
		end
	end

	// Ready falls while a channel holds its item, which gives back-pressure
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_awready <= !next_aw_held && !next_bvalid && !(s_axi_awvalid && s_axi_awready);
			s_axi_wready <= !next_w_held && !next_bvalid && !(s_axi_wvalid && s_axi_wready);
		end
	end

	// ==========================================================
	// AXI4-Lite read path
	logic next_arready;
	logic next_rvalid;
	logic [31:0] next_rdata;
	logic [1:0] next_rresp;

	always_comb begin
		next_rvalid = s_axi_rvalid;
		next_rdata = s_axi_rdata;
		next_rresp = s_axi_rresp;
		next_arready = !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rresp = `LIE_RESP_OKAY;
			unique case ({s_axi_araddr[7:2], 2'b00})
				`LIE_EVENT_SET_OFS, `LIE_EVENT_CLR_OFS: next_rdata = event_view;
				`LIE_MASK_SET_OFS, `LIE_MASK_CLR_OFS: next_rdata = mask;
				default: begin
					next_rdata = 32'h0000_0000;
					next_rresp = `LIE_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
			next_arready = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `LIE_RESP_OKAY;
		end else begin
			s_axi_arready <= next_arready;
			s_axi_rvalid <= next_rvalid;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
		end
	end

endmodule
`default_nettype wire

// ==== tb/lie_phy_model.sv ====
// Behavioural PHY side: status and bus reset levels, gated link clock
`timescale 1ns/1ps
`default_nettype none
module lie_phy_model
	import lie_pkg::*;
(
	output var lie_phy_in_type phy_in
);
	logic clk_on = 1'b0;
	// ==========================================
	// Link clock stands still unless the bench sets clk_on
	initial begin
		phy_in = '0;
		#3;
		forever begin
			#24;
			if (clk_on) begin
				phy_in.link_clk = ~phy_in.link_clk;
			end
		end
	end
	task automatic pulse(input int which);
		phy_in[which] = 1'b1;
		#60;
		phy_in[which] = 1'b0;
		#60;
	endtask
endmodule
`default_nettype wire

// ==== tb/lie_event_low_sva.sv ====
// Port-level checks of the link event block
`timescale 1ns/1ps
`default_nettype none
module lie_event_low_sva #(parameter int ADDR_W = 8) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic host_irq
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic [ADDR_W-1:0] aw_a = '0;
	logic [ADDR_W-1:0] ar_a = '0;
	// Global enable as software last left it, taken when the write response appears
	logic en_seen = 1'b0;
	logic w_en = 1'b0;
	logic b_prev = 1'b0;
	always_ff @(posedge aclk) begin
		b_prev <= s_axi_bvalid;
		if (s_axi_awvalid && s_axi_awready) aw_a <= s_axi_awaddr;
		if (s_axi_arvalid && s_axi_arready) ar_a <= s_axi_araddr;
		if (s_axi_wvalid && s_axi_wready) w_en <= s_axi_wdata[31] && s_axi_wstrb[3];
		if (!aresetn) en_seen <= 1'b0;
		else if (s_axi_bvalid && !b_prev && w_en && aw_a[7:2] == 6'h22) en_seen <= 1'b1;
		else if (s_axi_bvalid && !b_prev && w_en && aw_a[7:2] == 6'h23) en_seen <= 1'b0;
	end
	// ==========================================
	// Assertions
	chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##2 s_axi_bvalid) else $error("late write response");
	chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("late read response");
	chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken during response");
	chk_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during response");
	chk_rsvd_zero: assert property (s_axi_rvalid |-> s_axi_rdata[30:20] == 11'h0
		&& s_axi_rdata[14:10] == 5'h0) else $error("reserved bits not zero");
	chk_wr_decode: assert property (s_axi_bvalid |->
		s_axi_bresp == ((aw_a[7:4] == 4'h8) ? 2'b00 : 2'b10)) else $error("bad write resp");
	chk_rd_decode: assert property (s_axi_rvalid |->
		s_axi_rresp == ((ar_a[7:4] == 4'h8) ? 2'b00 : 2'b10)) else $error("bad read resp");
	chk_irq_gate: assert property (host_irq |-> en_seen)
		else $error("interrupt without enable");
	cover property (s_axi_bvalid);
	cover property (s_axi_rvalid);
	cover property ($rose(host_irq));
endmodule
bind lie_event_low lie_event_low_sva #(.ADDR_W(ADDR_W)) u_sva (.aclk, .aresetn, .s_axi_awaddr,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bresp,
	.s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
	.s_axi_rvalid, .host_irq);
`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench of the link event block
`timescale 1ns/1ps
`default_nettype none
`include "lie_regs.svh"
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin fails++; \
	$display("wrong value %s exp %h got %h", nm, e, s); end end
module tb;
	import lie_pkg::*;
	localparam int TMO = 16;
	logic aclk = 1'b0, aresetn = 1'b0, s_axi_bready = 1'b1, s_axi_rready = 1'b1;
	logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, host_irq;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	lie_event_in_type event_in = '0;
	lie_phy_in_type phy_in;
	logic [3:0] iso_rx_ctx_event = 4'h0, iso_rx_ctx_mask = 4'h0;
	logic [3:0] iso_tx_ctx_event = 4'h0, iso_tx_ctx_mask = 4'h0;
	int fails = 0, n_tests = 0, cyc = 0;
	integer seed = 32'h28e861d0;
	lie_event_low #(.LINK_TIMEOUT(TMO)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .event_in, .phy_in,
		.iso_rx_ctx_event, .iso_rx_ctx_mask, .iso_tx_ctx_event, .iso_tx_ctx_mask, .host_irq);
	lie_phy_model phy (.phy_in(phy_in));
	initial begin
		forever #2.5 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			conclude;
		end
	end
	// ==========================================
	// Bus tasks and expectations
	task automatic conclude;
		if (fails == 0 && n_tests > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		r = s_axi_bresp;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		r = s_axi_rresp;
		`CHK("rdata", e, s_axi_rdata)
	endtask
	task automatic ev(input int i);
		event_in <= lie_event_in_type'(10'h1 << i);
		@(posedge aclk);
		event_in <= '0;
		repeat (2) @(posedge aclk);
	endtask
	function automatic logic [31:0] ev_bit(input int i);
		case (i)
			9: ev_bit = 32'h0001_8000;
			8: ev_bit = 32'h0000_0200;
			7: ev_bit = 32'h0000_0100;
			default: ev_bit = 32'h1 << (i - 1);
		endcase
	endfunction
	// ==========================================
	// Scenarios
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
		rchk(8'h80, `LIE_EVENT_RESET);
		rchk(8'h88, `LIE_MASK_RESET);
		wr(8'h40, 32'hffff_ffff);
		`CHK("bresp", 2'b10, r)
		rchk(8'h40, 32'h0);
		`CHK("rresp", 2'b10, r)
		for (int i = 1; i < 10; i++) begin
			ev(i);
			rchk(8'h80, ev_bit(i));
			wr(8'h84, ev_bit(i));
			rchk(8'h84, 32'h0);
		end
		repeat (4) begin
			d = $random(seed);
			wr(8'h80, d);
			rchk(8'h80, d & `LIE_LATCHED_MASK);
			wr(8'h84, 32'hffff_ffff);
		end
		// Event pulse lands on the same edge as the clear write
		fork
			wr(8'h84, 32'hffff_ffff);
			begin
				@(posedge aclk);
				event_in <= lie_event_in_type'(10'h2);
				@(posedge aclk);
				event_in <= '0;
			end
		join
		rchk(8'h80, 32'h1);
		wr(8'h84, 32'hffff_ffff);
		ev(9);
		phy.pulse(1);
		@(posedge aclk);
		rchk(8'h80, 32'h0002_8000);
		phy.pulse(2);
		@(posedge aclk);
		rchk(8'h80, 32'h000a_8000);
		wr(8'h84, 32'hffff_ffff);
		ev(0);
		ev(0);
		rchk(8'h80, 32'h0004_0000);
		wr(8'h84, 32'hffff_ffff);
		repeat (TMO + 8) @(posedge aclk);
		rchk(8'h80, 32'h0004_0000);
		wr(8'h84, 32'hffff_ffff);
		phy.clk_on = 1'b1;
		repeat (20) @(posedge aclk);
		ev(0);
		repeat (TMO + 8) @(posedge aclk);
		rchk(8'h80, 32'h0);
		phy.clk_on = 1'b0;
		repeat (6) begin
			{iso_rx_ctx_event, iso_rx_ctx_mask, iso_tx_ctx_event, iso_tx_ctx_mask} <=
				16'($random(seed));
			repeat (3) @(posedge aclk);
			rchk(8'h80, {24'h0, |(iso_rx_ctx_event & iso_rx_ctx_mask),
				|(iso_tx_ctx_event & iso_tx_ctx_mask), 6'h0});
		end
		{iso_rx_ctx_event, iso_rx_ctx_mask, iso_tx_ctx_event, iso_tx_ctx_mask} <= 16'h0;
		wr(8'h88, 32'h8000_0001);
		rchk(8'h8c, 32'h8000_0001);
		repeat (3) @(posedge aclk);
		`CHK("host_irq", 1'b0, host_irq)
		wr(8'h80, 32'h1);
		repeat (3) @(posedge aclk);
		`CHK("host_irq", 1'b1, host_irq)
		wr(8'h8c, 32'h8000_0000);
		repeat (3) @(posedge aclk);
		`CHK("host_irq", 1'b0, host_irq)
		wr(8'h8c, 32'hffff_ffff);
		wr(8'h84, 32'hffff_ffff);
		wr(8'h88, 32'h8000_0080);
		repeat (3) @(posedge aclk);
		`CHK("host_irq", 1'b0, host_irq)
		iso_rx_ctx_event <= 4'h1;
		iso_rx_ctx_mask <= 4'h1;
		repeat (3) @(posedge aclk);
		`CHK("host_irq", 1'b1, host_irq)
		conclude;
	end
endmodule
`default_nettype wire
